// File: lnkc_defines.vh
// constants of the rs-232 to rs-485 link converter
`ifndef LNKC_DEFINES_VH
`define LNKC_DEFINES_VH
// ----------------------------------------------------------------------------
// clock
// ----------------------------------------------------------------------------
`define LNKC_CLK_HZ 100000000
`define LNKC_CLK_MHZ 100
// ----------------------------------------------------------------------------
// baud switch codes and rates
// ----------------------------------------------------------------------------
`define LNKC_CODE_115K 3'b110
`define LNKC_CODE_57K 3'b111
`define LNKC_CODE_38K 3'b000
`define LNKC_CODE_19K 3'b001
`define LNKC_CODE_9K6 3'b010
`define LNKC_CODE_4K8 3'b011
`define LNKC_CODE_2K4 3'b100
`define LNKC_CODE_1K2 3'b101
`define LNKC_BAUD_115K 115200
`define LNKC_BAUD_57K 57600
`define LNKC_BAUD_38K 38400
`define LNKC_BAUD_19K 19200
`define LNKC_BAUD_9K6 9600
`define LNKC_BAUD_4K8 4800
`define LNKC_BAUD_2K4 2400
`define LNKC_BAUD_1K2 1200
// ----------------------------------------------------------------------------
// turnaround times in microseconds and their cycle counts
// ----------------------------------------------------------------------------
`define LNKC_TURN_US_115K 150
`define LNKC_TURN_US_57K 300
`define LNKC_TURN_US_38K 500
`define LNKC_TURN_US_19K 1000
`define LNKC_TURN_US_9K6 2000
`define LNKC_TURN_US_4K8 4000
`define LNKC_TURN_US_2K4 7000
`define LNKC_TURN_US_1K2 14000
`define LNKC_TURN_CYC(us) ((us) * `LNKC_CLK_MHZ)
// probe retry period while waiting for the modem's answer
`define LNKC_RETRY_US 1000000
// ----------------------------------------------------------------------------
// register offsets, fields, reset values
// ----------------------------------------------------------------------------
`define LNKC_OFS_CTRL 8'h00
`define LNKC_OFS_STATUS 8'h04
`define LNKC_OFS_CMD_LEN 8'h08
`define LNKC_OFS_CMD_DATA 8'h0c
`define LNKC_CTRL_CMD_EN 0
`define LNKC_CTRL_DATA8 1
`define LNKC_CTRL_PAR_LSB 2
`define LNKC_CTRL_RAW_FMT 4
`define LNKC_CTRL_GO 5
`define LNKC_CTRL_RESET 6'h02
`define LNKC_ST_DIR 0
`define LNKC_ST_READY 1
`define LNKC_ST_LOCKED 2
`define LNKC_ST_CODE_LSB 4
`define LNKC_ST_STATE_LSB 8
`define LNKC_PAR_NONE 2'd0
`define LNKC_PAR_EVEN 2'd1
`define LNKC_PAR_ODD 2'd2
`define LNKC_RESP_OKAY 2'b00
`define LNKC_RESP_SLVERR 2'b10
// ----------------------------------------------------------------------------
// characters and rate-detect thresholds (cycles of one start bit)
// ----------------------------------------------------------------------------
`define LNKC_CHR_A 8'h41
`define LNKC_CHR_T 8'h54
`define LNKC_CHR_CR 8'h0d
`define LNKC_CHR_O 8'h4f
`define LNKC_CHR_K 8'h4b
`define LNKC_CHR_SEP 8'h00
`define LNKC_DET_115K 17'd1302
`define LNKC_DET_57K 17'd2170
`define LNKC_DET_38K 17'd3906
`define LNKC_DET_19K 17'd7812
`endif

// File: lnkc_link_converter.v
// control logic of the rs-232 to rs-485 half-duplex link converter
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "lnkc_defines.vh"
module lnkc_link_converter #(
  parameter CMD_AW = 6,
  parameter [20:0] TURN_CYC_115K = `LNKC_TURN_CYC(`LNKC_TURN_US_115K),
  parameter [20:0] TURN_CYC_57K = `LNKC_TURN_CYC(`LNKC_TURN_US_57K),
  parameter [20:0] TURN_CYC_38K = `LNKC_TURN_CYC(`LNKC_TURN_US_38K),
  parameter [20:0] TURN_CYC_19K = `LNKC_TURN_CYC(`LNKC_TURN_US_19K),
  parameter [20:0] TURN_CYC_9K6 = `LNKC_TURN_CYC(`LNKC_TURN_US_9K6),
  parameter [20:0] TURN_CYC_4K8 = `LNKC_TURN_CYC(`LNKC_TURN_US_4K8),
  parameter [20:0] TURN_CYC_2K4 = `LNKC_TURN_CYC(`LNKC_TURN_US_2K4),
  parameter [20:0] TURN_CYC_1K2 = `LNKC_TURN_CYC(`LNKC_TURN_US_1K2),
  parameter [26:0] RETRY_CYC = `LNKC_TURN_CYC(`LNKC_RETRY_US)
) (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // axi4-lite write
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // configuration switches
  input wire [2:0] sw_baud,
  input wire sw_multi_master_token_protocol,
  input wire sw_remote,
  input wire sw_frame11,
  // rs-232 side
  input wire rs232_txd,
  output reg rs232_rxd,
  output reg rts_out,
  output reg rts_oe,
  // rs-485 side
  input wire rs485_rxd,
  output reg rs485_txd,
  output reg rs485_de
);
  // --------------------------------------------------------------------------
  // rate and timing decode
  // --------------------------------------------------------------------------
  localparam ST_HOLD = 2'd0;
  localparam ST_SEND = 2'd1;
  localparam ST_WAIT = 2'd2;
  localparam ST_RUN = 2'd3;
  localparam PH_A = 3'd0;
  localparam PH_T = 3'd1;
  localparam PH_BODY = 3'd2;
  localparam PH_CR = 3'd3;
  localparam PH_DONE = 3'd4;

  // bit period in cycles for a baud code
  function [16:0] baud_div;
    input [2:0] code;
    reg [31:0] q;
    begin
      case (code)
        `LNKC_CODE_115K: q = `LNKC_CLK_HZ / `LNKC_BAUD_115K;
        `LNKC_CODE_57K: q = `LNKC_CLK_HZ / `LNKC_BAUD_57K;
        `LNKC_CODE_38K: q = `LNKC_CLK_HZ / `LNKC_BAUD_38K;
        `LNKC_CODE_19K: q = `LNKC_CLK_HZ / `LNKC_BAUD_19K;
        `LNKC_CODE_9K6: q = `LNKC_CLK_HZ / `LNKC_BAUD_9K6;
        `LNKC_CODE_4K8: q = `LNKC_CLK_HZ / `LNKC_BAUD_4K8;
        `LNKC_CODE_2K4: q = `LNKC_CLK_HZ / `LNKC_BAUD_2K4;
        default: q = `LNKC_CLK_HZ / `LNKC_BAUD_1K2;
      endcase
      baud_div = q[16:0];
    end
  endfunction

  // turnaround cycles for a baud code
  function [20:0] turn_cyc;
    input [2:0] code;
    begin
      case (code)
        `LNKC_CODE_115K: turn_cyc = TURN_CYC_115K;
        `LNKC_CODE_57K: turn_cyc = TURN_CYC_57K;
        `LNKC_CODE_38K: turn_cyc = TURN_CYC_38K;
        `LNKC_CODE_19K: turn_cyc = TURN_CYC_19K;
        `LNKC_CODE_9K6: turn_cyc = TURN_CYC_9K6;
        `LNKC_CODE_4K8: turn_cyc = TURN_CYC_4K8;
        `LNKC_CODE_2K4: turn_cyc = TURN_CYC_2K4;
        default: turn_cyc = TURN_CYC_1K2;
      endcase
    end
  endfunction

  // nearest of the five detectable rates for a measured start bit
  function [2:0] classify;
    input [16:0] width;
    begin
      if (width < `LNKC_DET_115K) classify = `LNKC_CODE_115K;
      else if (width < `LNKC_DET_57K) classify = `LNKC_CODE_57K;
      else if (width < `LNKC_DET_38K) classify = `LNKC_CODE_38K;
      else if (width < `LNKC_DET_19K) classify = `LNKC_CODE_19K;
      else classify = `LNKC_CODE_9K6;
    end
  endfunction

  // --------------------------------------------------------------------------
  // state and configuration
  // --------------------------------------------------------------------------
  reg [1:0] state;
  reg [2:0] phase;
  reg cmd_en, data8, raw_fmt, go;
  reg [1:0] par;
  reg [7:0] cmd_mem [0:(1 << CMD_AW) - 1];
  reg [CMD_AW-1:0] cmd_len, rd_idx;
  reg locked, measuring, line_q, dir_tx, got_o, fire_q;
  reg [2:0] lock_code;
  reg [16:0] low_cnt;
  reg [20:0] idle_cnt;
  reg [26:0] retry_cnt;
  wire mm = sw_multi_master_token_protocol;
  wire [2:0] rate_code = (mm && locked) ? lock_code : sw_baud;
  wire [16:0] bit_div = baud_div(rate_code);
  wire use_raw = !mm && raw_fmt;
  wire fmt_data8 = use_raw ? data8 : 1'b1;
  wire fmt_par_en = use_raw ? (par != `LNKC_PAR_NONE) : (mm | sw_frame11);
  wire fmt_par_odd = use_raw && (par == `LNKC_PAR_ODD);
  wire tx_ready, tx_line, rx_valid;
  wire [7:0] rx_data;
  wire [7:0] body = cmd_mem[rd_idx];
  wire body_end = (rd_idx == cmd_len) || (body == `LNKC_CHR_SEP);
  wire probe = mm && sw_remote;
  wire fire = (state == ST_SEND) && tx_ready && !fire_q && (phase != PH_DONE)
              && !(phase == PH_BODY && body_end);
  reg [7:0] tx_byte;

  // --------------------------------------------------------------------------
  // axi4-lite slave
  // --------------------------------------------------------------------------
  reg aw_hold, w_hold;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire do_write = aw_hold && w_hold && !s_axi_bvalid;
  wire [7:0] wa = {aw_addr[7:2], 2'b00};
  wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
  wire mem_we = do_write && wa == `LNKC_OFS_CMD_DATA && w_strb[0];
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready = !w_hold && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // address and data taken in either order; the response follows both
  always @(posedge sys_clk) begin
    if (rst) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LNKC_RESP_OKAY;
      {go, raw_fmt, par, data8, cmd_en} <= `LNKC_CTRL_RESET;
      cmd_len <= {CMD_AW{1'b0}};
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (do_write) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `LNKC_RESP_OKAY;
        if (wa == `LNKC_OFS_CTRL) begin
          if (w_strb[0])
            {go, raw_fmt, par, data8, cmd_en} <= w_data[`LNKC_CTRL_GO:0];
        end else if (wa == `LNKC_OFS_CMD_LEN) begin
          if (w_strb[0])
            cmd_len <= w_data[CMD_AW-1:0];
        end else if (wa == `LNKC_OFS_CMD_DATA) begin
          if (w_strb[0])
            cmd_len <= cmd_len + {{(CMD_AW-1){1'b0}}, 1'b1};
        end else if (wa != `LNKC_OFS_STATUS) begin
          s_axi_bresp <= `LNKC_RESP_SLVERR;
        end
      end
    end
  end

  // command string store, appended one byte per data write
  always @(posedge sys_clk) begin
    if (mem_we)
      cmd_mem[cmd_len] <= w_data[7:0];
  end

  // read answer one cycle after the address is taken
  always @(posedge sys_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `LNKC_RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end else if (s_axi_arvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `LNKC_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      if (ra == `LNKC_OFS_CTRL) begin
        s_axi_rdata[`LNKC_CTRL_GO:0] <= {go, raw_fmt, par, data8, cmd_en};
      end else if (ra == `LNKC_OFS_STATUS) begin
        s_axi_rdata[`LNKC_ST_DIR] <= dir_tx;
        s_axi_rdata[`LNKC_ST_READY] <= (state == ST_RUN);
        s_axi_rdata[`LNKC_ST_LOCKED] <= locked;
        s_axi_rdata[`LNKC_ST_CODE_LSB+2:`LNKC_ST_CODE_LSB] <= rate_code;
        s_axi_rdata[`LNKC_ST_STATE_LSB+1:`LNKC_ST_STATE_LSB] <= state;
      end else if (ra == `LNKC_OFS_CMD_LEN) begin
        s_axi_rdata[CMD_AW-1:0] <= cmd_len;
      end else if (ra != `LNKC_OFS_CMD_DATA) begin
        s_axi_rresp <= `LNKC_RESP_SLVERR;
      end
    end
  end

  // --------------------------------------------------------------------------
  // start-up sequencer: probe or stored commands
  // --------------------------------------------------------------------------
  // byte for the current phase
  always @* begin
    case (phase)
      PH_A: tx_byte = `LNKC_CHR_A;
      PH_T: tx_byte = `LNKC_CHR_T;
      PH_BODY: tx_byte = body;
      default: tx_byte = `LNKC_CHR_CR;
    endcase
  end

  // forwarding stays off until the sequence has finished
  always @(posedge sys_clk) begin
    if (rst) begin
      state <= ST_HOLD;
      phase <= PH_A;
      rd_idx <= {CMD_AW{1'b0}};
      retry_cnt <= 27'h000_0000;
      fire_q <= 1'b0;
      got_o <= 1'b0;
    end else begin
      fire_q <= fire; // tx needs a cycle to report busy
      if (rx_valid)
        got_o <= (rx_data == `LNKC_CHR_O);
      case (state)
        ST_HOLD: begin
          phase <= PH_A;
          rd_idx <= {CMD_AW{1'b0}};
          if (mm)
            state <= probe ? ST_SEND : ST_RUN;
          else if (go)
            state <= (cmd_en && cmd_len != {CMD_AW{1'b0}}) ? ST_SEND : ST_RUN;
        end
        ST_SEND: begin
          if (phase == PH_BODY && body_end) begin
            phase <= PH_CR; // end of one string: sent on its own
            if (rd_idx != cmd_len)
              rd_idx <= rd_idx + {{(CMD_AW-1){1'b0}}, 1'b1};
          end else if (fire) begin
            if (phase == PH_T)
              phase <= probe ? PH_CR : PH_BODY;
            else if (phase == PH_BODY)
              rd_idx <= rd_idx + {{(CMD_AW-1){1'b0}}, 1'b1};
            else if (phase == PH_CR)
              phase <= PH_DONE;
            else
              phase <= PH_T;
          end else if (phase == PH_DONE && tx_ready && !fire_q) begin
            phase <= PH_A;
            retry_cnt <= 27'h000_0000;
            if (probe)
              state <= ST_WAIT;
            else if (rd_idx == cmd_len)
              state <= ST_RUN;
          end
        end
        ST_WAIT: begin
          if (rx_valid && got_o && rx_data == `LNKC_CHR_K) begin
            state <= ST_RUN;
          end else if (retry_cnt == RETRY_CYC - 27'h000_0001) begin
            state <= ST_SEND;
          end else begin
            retry_cnt <= retry_cnt + 27'h000_0001;
          end
        end
        default: state <= ST_RUN;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // rate detection from the first start bit seen from the modem
  // --------------------------------------------------------------------------
  // a lock made mid-character garbles that character; the probe retry covers it
  always @(posedge sys_clk) begin
    if (rst) begin
      line_q <= 1'b1;
      measuring <= 1'b0;
      locked <= 1'b0;
      lock_code <= `LNKC_CODE_9K6;
      low_cnt <= 17'h0_0000;
    end else begin
      line_q <= rs232_txd;
      if (mm && !locked) begin
        if (line_q && !rs232_txd) begin
          measuring <= 1'b1;
          low_cnt <= 17'h0_0001;
        end else if (measuring && !rs232_txd && low_cnt != 17'h1_ffff) begin
          low_cnt <= low_cnt + 17'h0_0001;
        end else if (measuring && rs232_txd) begin
          measuring <= 1'b0;
          locked <= 1'b1;
          lock_code <= classify(low_cnt);
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // direction control and pins
  // --------------------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      dir_tx <= 1'b0;
      idle_cnt <= 21'h00_0000;
      rs485_txd <= 1'b1;
      rs485_de <= 1'b0;
      rs232_rxd <= 1'b1;
      rts_out <= 1'b0;
      rts_oe <= 1'b0;
    end else begin
      if (state != ST_RUN) begin
        dir_tx <= 1'b0;
      end else if (!rs232_txd) begin
        dir_tx <= 1'b1;
        idle_cnt <= 21'h00_0000;
      end else if (dir_tx) begin
        if (idle_cnt >= turn_cyc(rate_code) - 21'h00_0001)
          dir_tx <= 1'b0;
        else
          idle_cnt <= idle_cnt + 21'h00_0001;
      end
      rs485_txd <= rs232_txd;
      rs485_de <= (state == ST_RUN) && (dir_tx || !rs232_txd);
      if (state == ST_SEND)
        rs232_rxd <= tx_line;
      else if (state == ST_RUN && !dir_tx)
        rs232_rxd <= rs485_rxd;
      else
        rs232_rxd <= 1'b1;
      rts_oe <= sw_remote;
      rts_out <= sw_remote && (state == ST_SEND || dir_tx);
    end
  end

  // --------------------------------------------------------------------------
  // character engines for the start-up exchange
  // --------------------------------------------------------------------------
  lnkc_uart_tx u_tx (
    .sys_clk(sys_clk),
    .rst(rst),
    .bit_div(bit_div),
    .data8(fmt_data8),
    .par_en(fmt_par_en),
    .par_odd(fmt_par_odd),
    .start(fire),
    .data(tx_byte),
    .ready(tx_ready),
    .line(tx_line)
  );

  lnkc_uart_rx u_rx (
    .sys_clk(sys_clk),
    .rst(rst),
    .bit_div(bit_div),
    .data8(fmt_data8),
    .par_en(fmt_par_en),
    .line(rs232_txd),
    .data(rx_data),
    .valid(rx_valid)
  );
endmodule // lnkc_link_converter
`default_nettype wire

// File: lnkc_link_converter_props.sv
// port checker for the link converter
`timescale 1ns/100ps
`default_nettype none
module lnkc_link_converter_props #(
  parameter [20:0] TURN_CYC_115K = 21'd20,
  parameter [20:0] TURN_CYC_1K2 = 21'd160
) (
  input wire logic sys_clk, rst, sw_remote, rts_oe, rs232_txd, rs485_txd, rs485_de,
  input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire logic s_axi_bvalid, s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic [31:0] s_axi_rdata
);
  logic [31:0] idle;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // idle run of the rs-232 line, bounds the turnaround
  always @(posedge sys_clk) begin
    if (rst || !rs232_txd) idle <= 32'h0;
    else idle <= idle + 32'h1;
  end
  a_rts_role: assert property (!$past(rst) |-> rts_oe == $past(sw_remote))
    else $error("rts enable off role");
  a_fwd_copy: assert property (rs485_de |-> rs485_txd == $past(rs232_txd))
    else $error("bad forwarded bit");
  a_de_cause: assert property ($rose(rs485_de) |-> !$past(rs232_txd))
    else $error("driver on unprompted");
  a_de_keep: assert property (rs485_de && !rs232_txd |=> rs485_de)
    else $error("driver off while busy");
  a_turn_max: assert property (rs485_de |-> idle <= TURN_CYC_1K2 + 2)
    else $error("turnaround too long");
  a_turn_min: assert property ($fell(rs485_de) |-> idle >= TURN_CYC_115K)
    else $error("turnaround too short");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  c_de_on: cover property ($rose(rs485_de));
  c_de_off: cover property ($fell(rs485_de));
  c_role: cover property (rts_oe);
endmodule // lnkc_link_converter_props
bind lnkc_link_converter lnkc_link_converter_props #(.TURN_CYC_115K(TURN_CYC_115K),
  .TURN_CYC_1K2(TURN_CYC_1K2)) i_lnkc_link_converter_props (.*);
`default_nettype wire

// File: lnkc_link_converter_tb_top.sv
// bench for the link converter
`timescale 1ns/100ps
`default_nettype none
module lnkc_link_converter_tb_top;
  logic sys_clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rs232_rxd;
  logic sw_multi_master_token_protocol, sw_remote, sw_frame11, tb_txd, rs485_rxd, modem_txd;
  logic rts_out, rts_oe, rs485_txd, rs485_de, got_probe;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [2:0] sw_baud;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  int num_errors = 0, n_compared = 0;
  wire rs232_txd = tb_txd & modem_txd;
  // short turnarounds keep the run brief
  lnkc_link_converter #(.TURN_CYC_115K(21'd20), .TURN_CYC_38K(21'd60), .TURN_CYC_1K2(21'd160))
    i_lnkc_link_converter (.*);
  lnkc_modem_model i_lnkc_modem_model (.sys_clk(sys_clk), .line_in(rs232_rxd),
    .line_out(modem_txd), .got_probe(got_probe));
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bus cycles; each wait is bounded and a hang ends the run
  // handshakes looked at mid-cycle, acted on at the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw_go, w_go, b_go;
    @(posedge sys_clk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (n = 0; n < 50; n++) begin
      @(negedge sys_clk);
      aw_go = s_axi_awvalid && s_axi_awready;
      w_go = s_axi_wvalid && s_axi_wready;
      b_go = s_axi_bvalid;
      if (b_go) rs = s_axi_bresp;
      @(posedge sys_clk);
      if (aw_go) s_axi_awvalid <= 1'b0;
      if (w_go) s_axi_wvalid <= 1'b0;
      if (b_go) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 50) begin
      num_errors++;
      summarize();
    end
  endtask
  task automatic rdr(input logic [7:0] a);
    int n;
    logic ar_go, r_go;
    @(posedge sys_clk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    for (n = 0; n < 50; n++) begin
      @(negedge sys_clk);
      ar_go = s_axi_arvalid && s_axi_arready;
      r_go = s_axi_rvalid;
      if (r_go) {rd, rs} = {s_axi_rdata, s_axi_rresp};
      @(posedge sys_clk);
      if (ar_go) s_axi_arvalid <= 1'b0;
      if (r_go) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 50) begin
      num_errors++;
      summarize();
    end
  endtask
  // one character start on the rs-232 line, then idle until turnaround
  task automatic fwd(input int t);
    int c;
    @(posedge sys_clk);
    tb_txd <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("de", 1, rs485_de);
    chk("txd", 0, rs485_txd);
    chk("rts", sw_remote, rts_out);
    tb_txd <= 1'b1;
    for (c = 0; c < 400 && rs485_de !== 1'b0; c++) @(posedge sys_clk);
    chk("turn", 1, c >= t && c <= t + 3);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    {rst, tb_txd, rs485_rxd, sw_frame11, s_axi_wstrb} = 8'hff;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, rd} = 80'h0;
    {sw_baud, sw_multi_master_token_protocol, sw_remote} = 5'h0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    rdr(8'h00);
    chk("ctrl", 2, rd);
    rdr(8'h10);
    chk("slverr", 2, rs);
    rdr(8'h04);
    chk("state", 0, rd[9:8]);
    tb_txd <= 1'b0;
    repeat (9) @(posedge sys_clk);
    chk("refused", 0, rs485_de);
    tb_txd <= 1'b1;
    wr(8'h00, 32'h22);
    chk("wresp", 0, rs);
    repeat (4) @(posedge sys_clk);
    rdr(8'h04);
    chk("run", 3, rd[9:8]);
    chk("code", 0, rd[6:4]);
    chk("oe", 0, rts_oe);
    fwd(60);
    $display("test mode zero done");
    rst <= 1'b1;
    {sw_baud, sw_multi_master_token_protocol, sw_remote} <= 5'h1b;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    rd = 32'h0;
    for (int i = 0; i < 250 && rd[9:8] !== 2'd3; i++) begin
      repeat (300) @(posedge sys_clk);
      rdr(8'h04);
    end
    chk("oe", 1, rts_oe);
    chk("probe", 1, got_probe);
    chk("mmrun", 3, rd[9:8]);
    chk("lock", 1, rd[2]);
    chk("code", 6, rd[6:4]);
    fwd(20);
    rs485_rxd <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("rxd", 0, rs232_rxd);
    rs485_rxd <= 1'b1;
    $display("test multi master done");
    summarize();
  end
endmodule // lnkc_link_converter_tb_top
`default_nettype wire

// File: lnkc_modem_model.sv
// modem model: takes 8e1 characters, answers the attention probe
`timescale 1ns/100ps
`default_nettype none
module lnkc_modem_model #(
  parameter BIT = 868
) (
  input wire logic sys_clk,
  input wire logic line_in,
  output logic line_out,
  output logic got_probe
);
  logic [7:0] ch;
  logic [23:0] seen;
  // one frame: start, 8 data lsb first, even parity, stop
  task automatic tx(input logic [7:0] b);
    logic [10:0] f;
    f = {1'b1, ^b, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line_out <= f[i];
      repeat (BIT) @(posedge sys_clk);
    end
  endtask
  // mid-bit sampling; parity ignored, like a lenient modem
  initial begin
    line_out = 1'b1;
    got_probe = 1'b0;
    seen = 24'h0;
    forever begin
      @(negedge line_in);
      repeat (BIT / 2) @(posedge sys_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge sys_clk);
        ch[i] = line_in;
      end
      repeat (2 * BIT) @(posedge sys_clk);
      seen = {seen[15:0], ch};
      if (seen == 24'h41540d) begin
        got_probe <= 1'b1;
        tx(8'h4f);
        tx(8'h4b);
      end
    end
  end
endmodule // lnkc_modem_model
`default_nettype wire

// File: lnkc_uart_rx.v
// serial character receiver, mid-bit sampling, parity bit skipped
`timescale 1ns/100ps
`default_nettype none
module lnkc_uart_rx (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // format
  input wire [16:0] bit_div,
  input wire data8,
  input wire par_en,
  // line and character
  input wire line,
  output reg [7:0] data,
  output reg valid
);
  reg active;
  reg [16:0] div_cnt;
  reg [3:0] idx;
  reg [7:0] sh;
  wire [3:0] last = (data8 ? 4'h9 : 4'h8) + {3'b000, par_en};

  // start found on a low level, then each bit sampled at its middle
  always @(posedge sys_clk) begin
    if (rst) begin
      active <= 1'b0;
      div_cnt <= 17'h0_0000;
      idx <= 4'h0;
      sh <= 8'h00;
      data <= 8'h00;
      valid <= 1'b0;
    end else begin
      valid <= 1'b0;
      if (!active) begin
        if (!line) begin
          active <= 1'b1;
          idx <= 4'h0;
          div_cnt <= {1'b0, bit_div[16:1]};
        end
      end else if (div_cnt != 17'h0_0000) begin
        div_cnt <= div_cnt - 17'h0_0001;
      end else begin
        div_cnt <= bit_div - 17'h0_0001;
        idx <= idx + 4'h1;
        if (idx == 4'h0 && line) begin
          active <= 1'b0; // glitch, not a start bit
        end else if (idx == last) begin
          active <= 1'b0;
          valid <= line;
          data <= data8 ? sh : {1'b0, sh[7:1]};
        end else if (idx != 4'h0 && idx <= (data8 ? 4'h8 : 4'h7)) begin
          sh <= {line, sh[7:1]};
        end
      end
    end
  end
endmodule // lnkc_uart_rx
`default_nettype wire

// File: lnkc_uart_tx.v
// serial character transmitter with selectable data bits and parity
`timescale 1ns/100ps
`default_nettype none
module lnkc_uart_tx (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // format
  input wire [16:0] bit_div,
  input wire data8,
  input wire par_en,
  input wire par_odd,
  // character
  input wire start,
  input wire [7:0] data,
  output wire ready,
  // line
  output reg line
);
  reg active;
  reg [16:0] div_cnt;
  reg [3:0] bit_cnt;
  reg [11:0] frame;
  wire par_bit = (data8 ? ^data : ^data[6:0]) ^ par_odd;
  wire p_slot = par_en ? par_bit : 1'b1;

  assign ready = ~active;

  // shift the frame out lsb first; the bit count ends it after one stop bit, spare high ones are never sent
  always @(posedge sys_clk) begin
    if (rst) begin
      active <= 1'b0;
      div_cnt <= 17'h0_0000;
      bit_cnt <= 4'h0;
      frame <= 12'hfff;
      line <= 1'b1;
    end else if (!active) begin
      line <= 1'b1;
      if (start) begin
        active <= 1'b1;
        frame <= data8 ? {2'b11, p_slot, data, 1'b0} : {3'b111, p_slot, data[6:0], 1'b0};
        bit_cnt <= (data8 ? 4'ha : 4'h9) + {3'b000, par_en};
        div_cnt <= 17'h0_0000;
      end
    end else if (div_cnt == 17'h0_0000) begin
      if (bit_cnt == 4'h0) begin
        active <= 1'b0;
        line <= 1'b1;
      end else begin
        line <= frame[0];
        frame <= {1'b1, frame[11:1]};
        bit_cnt <= bit_cnt - 4'h1;
        div_cnt <= bit_div - 17'h0_0001;
      end
    end else begin
      div_cnt <= div_cnt - 17'h0_0001;
    end
  end
endmodule // lnkc_uart_tx
`default_nettype wire
